// [include/agu_pkg.sv]
// package of constants and carriers for the address generation block
package agu_pkg;
    localparam logic [15:0] CALL_PAGE_BASE = 16'h0800;
    localparam logic [15:0] CALL_PAGE_LAST = 16'h0fff;
    localparam logic [15:0] VEC_TABLE_BASE = 16'h0040;
    localparam logic [15:0] VEC_TABLE_LAST = 16'h007f;
    localparam logic [7:0] SADDR_HIGH = 8'hfe;
    localparam logic [7:0] SADDR_WRAP = 8'h20;
    localparam logic [7:0] SFR_HIGH = 8'hff;
    localparam int VEC_LSB = 1;
    localparam int VEC_MSB = 5;
    // byte register indices
    localparam logic [2:0] REG_X = 3'h0;
    localparam logic [2:0] REG_A = 3'h1;
    localparam logic [2:0] REG_C = 3'h2;
    localparam logic [2:0] REG_B = 3'h3;
    localparam logic [2:0] REG_E = 3'h4;
    localparam logic [2:0] REG_D = 3'h5;
    localparam logic [2:0] REG_L = 3'h6;
    localparam logic [2:0] REG_H = 3'h7;
    // pair indices
    localparam logic [1:0] RP_AX = 2'h0;
    localparam logic [1:0] RP_BC = 2'h1;
    localparam logic [1:0] RP_DE = 2'h2;
    localparam logic [1:0] RP_HL = 2'h3;

    typedef enum logic [1:0] {BR_NONE, BR_LONG, BR_PAGE, BR_VECTOR} agu_br_e;
    typedef enum logic [2:0] {OP_NONE, OP_DIRECT, OP_SHORT, OP_SFR, OP_INDIRECT,
        OP_BASED, OP_INDEXED, OP_IMPLIED} agu_op_e;

    // decoded request from the instruction decoder
    typedef struct packed {
        agu_br_e br;
        agu_op_e op;
        logic [7:0] opcode;
        logic [15:0] imm16;
        logic [7:0] imm8;
        logic [2:0] reg_code;
        logic idx_sel_b;
        logic ind_sel_hl;
    } agu_req_s;

    // generated addresses, registered
    typedef struct packed {
        logic pc_load;
        logic [15:0] pc;
        logic vec_fetch;
        logic [15:0] vec_addr;
        logic mem_valid;
        logic [15:0] mem_addr;
        logic [4:0] reg_index;
        logic [4:0] acc_index;
        logic [4:0] acc_pair_index;
    } agu_rsp_s;
endpackage

// [design/agu_core.sv]
// address generation for branch targets and operand addresses
`timescale 1ns/1ps
// Summary of operation
// - long call and branch load the full 16-bit target into the PC.
// - short page call lands only inside 0800H to 0FFFH.
// - table call uses opcode bits 1 to 5 to pick an entry, loads it.
// - vector table sits at 40H to 7FH; entries may point anywhere.
// - register jump copies the AX pair into the PC.
// - multiply uses A as multiplicand, product goes to AX.
// - word divide reads dividend from AX and writes quotient to AX.
// - decimal adjust and digit rotates operate on A.
// - byte register chosen by 3-bit code inside the selected bank.
// - X,A,C,B,E,D,L,H are 0..7; AX,BC,DE,HL are pairs 0..3.
// - direct addressing uses the 16-bit immediate unchanged.
// - short direct maps the byte into FE20H to FF1FH.
// - bit 8 clear for 20H..FFH, set for 00H..1FH, upper bits ones.
// - high-speed RAM at FE20H..FEFFH, registers at FF00H..FF1FH.
// - register addressing reaches FF00H..FFCFH and FFE0H..FFFFH; the code maps FFD0H..FFDFH as well.
// - register indirect uses banked DE or HL as the address.
// - based adds zero-extended offset to banked HL, carry dropped.
// - based indexed adds zero-extended B or C to HL, carry dropped.
module agu_core
(
    input wire logic clk,
    input wire logic rstn,
    input wire agu_pkg::agu_req_s req,
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    input wire logic [15:0] vec_data,
    input wire logic [63:0] bank_file,
    output agu_pkg::agu_rsp_s rsp
);

    ////////////////////////////////////////////////////////////////////////
    // reset release through two flops
    logic rst_meta_r;
    logic rst_sync_r;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register bank helpers
    // bank_file holds the eight bytes of the currently selected bank, index 0 at bits 7:0
    function automatic logic [4:0] bank_index(input logic [1:0] bank, input logic [2:0] code);
        bank_index = {bank, code};
    endfunction

    function automatic logic [7:0] reg_byte(input logic [63:0] file, input logic [2:0] code);
        reg_byte = file[code * 8 +: 8];
    endfunction

    function automatic logic [15:0] reg_pair(input logic [63:0] file, input logic [1:0] rp);
        reg_pair = {file[rp * 16 + 8 +: 8], file[rp * 16 +: 8]};
    endfunction

    logic [1:0] bank;
    logic [15:0] hl_pair;
    logic [15:0] ax_pair;
    logic [7:0] idx_byte;
    logic [7:0] short_hi;

    assign bank = {bank_select_high, bank_select_low};
    assign hl_pair = reg_pair(bank_file, agu_pkg::RP_HL);
    assign ax_pair = reg_pair(bank_file, agu_pkg::RP_AX);
    assign idx_byte = req.idx_sel_b ? reg_byte(bank_file, agu_pkg::REG_B)
                                    : reg_byte(bank_file, agu_pkg::REG_C);
    // bit 8 follows the wrap so the window stays contiguous
    assign short_hi = (req.imm8 < agu_pkg::SADDR_WRAP) ? agu_pkg::SFR_HIGH
                                                       : agu_pkg::SADDR_HIGH;

    ////////////////////////////////////////////////////////////////////////
    // branch target generation
    logic [15:0] vec_entry;
    assign vec_entry = agu_pkg::VEC_TABLE_BASE
        | {10'h000, req.opcode[agu_pkg::VEC_MSB:agu_pkg::VEC_LSB], 1'b0};

    // vector fetch is issued first; the entry arrives on vec_data the next cycle
    logic vec_wait_r;

    always_ff @(posedge clk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            rsp.pc_load <= 1'b0;
            rsp.pc <= 16'h0000;
            rsp.vec_fetch <= 1'b0;
            rsp.vec_addr <= 16'h0000;
            vec_wait_r <= 1'b0;
        end
        else
        begin
            rsp.pc_load <= 1'b0;
            rsp.vec_fetch <= 1'b0;
            vec_wait_r <= 1'b0;
            if (vec_wait_r)
            begin
                rsp.pc_load <= 1'b1;
                rsp.pc <= vec_data;
            end
            else
            begin
                unique case (req.br)
                    agu_pkg::BR_NONE:
                    begin
                        if (req.op == agu_pkg::OP_IMPLIED && req.reg_code == agu_pkg::REG_X)
                        begin
                            rsp.pc_load <= 1'b1;
                            rsp.pc <= ax_pair;
                        end
                    end
                    agu_pkg::BR_LONG:
                    begin
                        rsp.pc_load <= 1'b1;
                        rsp.pc <= req.imm16;
                    end
                    agu_pkg::BR_PAGE:
                    begin
                        rsp.pc_load <= 1'b1;
                        rsp.pc <= agu_pkg::CALL_PAGE_BASE
                                  | {5'h00, req.imm16[10:0]};
                    end
                    agu_pkg::BR_VECTOR:
                    begin
                        rsp.vec_fetch <= 1'b1;
                        rsp.vec_addr <= vec_entry;
                        vec_wait_r <= 1'b1;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // operand address generation
    always_ff @(posedge clk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            rsp.mem_valid <= 1'b0;
            rsp.mem_addr <= 16'h0000;
        end
        else
        begin
            rsp.mem_valid <= 1'b1;
            unique case (req.op)
                agu_pkg::OP_DIRECT: rsp.mem_addr <= req.imm16;
                agu_pkg::OP_SHORT: rsp.mem_addr <= {short_hi, req.imm8};
                agu_pkg::OP_SFR: rsp.mem_addr <= {agu_pkg::SFR_HIGH, req.imm8};
                agu_pkg::OP_INDIRECT:
                    rsp.mem_addr <= reg_pair(bank_file, req.ind_sel_hl ? agu_pkg::RP_HL
                                                                      : agu_pkg::RP_DE);
                agu_pkg::OP_BASED:
                    rsp.mem_addr <= 16'(hl_pair + {8'h00, req.imm8});
                agu_pkg::OP_INDEXED:
                    rsp.mem_addr <= 16'(hl_pair + {8'h00, idx_byte});
                default:
                begin
                    rsp.mem_valid <= 1'b0;
                    rsp.mem_addr <= 16'h0000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register file indices; implied forms always point at A and AX
    always_ff @(posedge clk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            rsp.reg_index <= 5'h00;
            rsp.acc_index <= 5'h00;
            rsp.acc_pair_index <= 5'h00;
        end
        else
        begin
            rsp.reg_index <= bank_index(bank, req.reg_code);
            rsp.acc_index <= bank_index(bank, agu_pkg::REG_A);
            rsp.acc_pair_index <= bank_index(bank, agu_pkg::REG_X);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_vec_req;
        req.br == agu_pkg::BR_VECTOR && !vec_wait_r;
    endsequence
    sequence s_vec_load;
        rsp.vec_fetch ##1 rsp.pc_load;
    endsequence

    property p_long;
        @(posedge clk) disable iff (!rst_sync_r)
        (req.br == agu_pkg::BR_LONG && !vec_wait_r) |=> rsp.pc_load && rsp.pc == $past(req.imm16);
    endproperty
    a_long: assert property (p_long) else $error("long target wrong");

    property p_page;
        @(posedge clk) disable iff (!rst_sync_r)
        (req.br == agu_pkg::BR_PAGE && !vec_wait_r)
        |=> rsp.pc >= agu_pkg::CALL_PAGE_BASE && rsp.pc <= agu_pkg::CALL_PAGE_LAST;
    endproperty
    a_page: assert property (p_page) else $error("page call out of page");

    property p_vec;
        @(posedge clk) disable iff (!rst_sync_r)
        s_vec_req |=> s_vec_load ##0 rsp.pc == $past(vec_data);
    endproperty
    a_vec: assert property (p_vec) else $error("vector call sequence wrong");

    property p_vec_range;
        @(posedge clk) disable iff (!rst_sync_r)
        rsp.vec_fetch |-> rsp.vec_addr >= agu_pkg::VEC_TABLE_BASE
            && rsp.vec_addr <= agu_pkg::VEC_TABLE_LAST && !rsp.vec_addr[0];
    endproperty
    a_vec_range: assert property (p_vec_range) else $error("vector outside table");

    property p_short;
        @(posedge clk) disable iff (!rst_sync_r)
        req.op == agu_pkg::OP_SHORT |=> rsp.mem_addr >= 16'hfe20 && rsp.mem_addr <= 16'hff1f
            && rsp.mem_addr[7:0] == $past(req.imm8);
    endproperty
    a_short: assert property (p_short) else $error("short direct outside window");

    property p_sfr;
        @(posedge clk) disable iff (!rst_sync_r)
        req.op == agu_pkg::OP_SFR |=> rsp.mem_addr == {8'hff, $past(req.imm8)};
    endproperty
    a_sfr: assert property (p_sfr) else $error("register address wrong");

    property p_based;
        @(posedge clk) disable iff (!rst_sync_r)
        req.op == agu_pkg::OP_BASED
        |=> rsp.mem_addr == 16'($past(hl_pair) + {8'h00, $past(req.imm8)});
    endproperty
    a_based: assert property (p_based) else $error("based sum wrong");

    property p_indexed;
        @(posedge clk) disable iff (!rst_sync_r)
        req.op == agu_pkg::OP_INDEXED
        |=> rsp.mem_addr == 16'($past(hl_pair) + {8'h00, $past(idx_byte)});
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed sum wrong");

    property p_direct;
        @(posedge clk) disable iff (!rst_sync_r)
        req.op == agu_pkg::OP_DIRECT |=> rsp.mem_valid && rsp.mem_addr == $past(req.imm16);
    endproperty
    a_direct: assert property (p_direct) else $error("direct address wrong");

endmodule // agu_core

// [verification/agu_core_tb.sv]
// self-checking bench for the address generation block
`timescale 1ns/1ps
module agu_core_tb;
    logic clk;
    logic rstn;
    agu_pkg::agu_req_s req;
    logic bank_select_low;
    logic bank_select_high;
    logic [15:0] vec_data;
    logic [63:0] bank_file;
    agu_pkg::agu_rsp_s rsp;
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;

    agu_core dut_u
    (
        .clk(clk),
        .rstn(rstn),
        .req(req),
        .bank_select_low(bank_select_low),
        .bank_select_high(bank_select_high),
        .vec_data(vec_data),
        .bank_file(bank_file),
        .rsp(rsp)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // 40 ns clock and a hang guard far above the expected run length
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            error_cnt++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // compare, verdict and stimulus helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("errors %0d, checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // drive one request at the falling edge, return after the answer has landed
    task automatic step(input agu_pkg::agu_br_e br, input agu_pkg::agu_op_e op,
        input logic [15:0] imm16, input logic [7:0] imm8, input logic [2:0] code,
        input logic sel);
        agu_pkg::agu_req_s r;
        // build the request aside so the port changes only once per step
        r = '0;
        r.br = br;
        r.op = op;
        r.opcode = imm8;
        r.imm16 = imm16;
        r.imm8 = imm8;
        r.reg_code = code;
        r.idx_sel_b = sel;
        r.ind_sel_hl = sel;
        req = r;
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic mem(input agu_pkg::agu_op_e op, input logic [15:0] imm16,
        input logic [7:0] imm8, input logic sel, input logic [15:0] exp);
        step(agu_pkg::BR_NONE, op, imm16, imm8, 3'h0, sel);
        chk({15'h0, rsp.mem_valid}, 16'h1);
        chk(rsp.mem_addr, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // branch targets: long, fixed page at its top end and mid-page, vector table
    task automatic t_branch();
        step(agu_pkg::BR_LONG, agu_pkg::OP_NONE, 16'hbeef, 8'h00, 3'h0, 1'b0);
        chk({15'h0, rsp.pc_load}, 16'h1);
        chk(rsp.pc, 16'hbeef);
        step(agu_pkg::BR_PAGE, agu_pkg::OP_NONE, 16'hffff, 8'h00, 3'h0, 1'b0);
        chk(rsp.pc, 16'h0fff);
        step(agu_pkg::BR_PAGE, agu_pkg::OP_NONE, 16'hf123, 8'h00, 3'h0, 1'b0);
        chk(rsp.pc, 16'h0923);
        step(agu_pkg::BR_VECTOR, agu_pkg::OP_NONE, 16'h0000, 8'hff, 3'h0, 1'b0);
        chk({15'h0, rsp.vec_fetch}, 16'h1);
        chk(rsp.vec_addr, 16'h007e);
        vec_data = 16'hc3a5;
        step(agu_pkg::BR_LONG, agu_pkg::OP_NONE, 16'h1111, 8'h00, 3'h0, 1'b0);
        chk({15'h0, rsp.pc_load}, 16'h1);
        chk(rsp.pc, 16'hc3a5);
        // register jump: AX of bank 0 is {A, X} = 7988
        step(agu_pkg::BR_NONE, agu_pkg::OP_IMPLIED, 16'h0000, 8'h00, 3'h0, 1'b0);
        chk({15'h0, rsp.pc_load}, 16'h1);
        chk(rsp.pc, 16'h7988);
        step(agu_pkg::BR_VECTOR, agu_pkg::OP_NONE, 16'h0000, 8'hc1, 3'h0, 1'b0);
        chk(rsp.vec_addr, 16'h0040);
    endtask

    // register codes in every bank, with the implied accumulator indices
    task automatic t_regs();
        for (int b = 0; b < 4; b++)
            for (int c = 0; c < 8; c++)
            begin
                bank_select_low = b[0];
                bank_select_high = b[1];
                step(agu_pkg::BR_NONE, agu_pkg::OP_IMPLIED, 16'h0, 8'h0, c[2:0], 1'b0);
                chk({11'h0, rsp.reg_index}, {11'h0, b[1:0], c[2:0]});
                chk({11'h0, rsp.acc_index}, {11'h0, b[1:0], agu_pkg::REG_A});
                chk({11'h0, rsp.acc_pair_index}, {11'h0, b[1:0], 3'h0});
                chk({15'h0, rsp.mem_valid}, 16'h0);
            end
    endtask

    // operand address forms, boundaries and carry drop
    task automatic t_mem();
        mem(agu_pkg::OP_DIRECT, 16'hfe00, 8'h00, 1'b0, 16'hfe00);
        mem(agu_pkg::OP_SHORT, 16'h0, 8'h20, 1'b0, 16'hfe20);
        // operands are given at odd as well as even addresses, with no alignment
        mem(agu_pkg::OP_SHORT, 16'h0, 8'h30, 1'b0, 16'hfe30);
        mem(agu_pkg::OP_SFR, 16'h0, 8'h20, 1'b0, 16'hff20);
        mem(agu_pkg::OP_SHORT, 16'h0, 8'hff, 1'b0, 16'hfeff);
        mem(agu_pkg::OP_SHORT, 16'h0, 8'h00, 1'b0, 16'hff00);
        mem(agu_pkg::OP_SHORT, 16'h0, 8'h1f, 1'b0, 16'hff1f);
        mem(agu_pkg::OP_SFR, 16'h0, 8'hcf, 1'b0, 16'hffcf);
        mem(agu_pkg::OP_SFR, 16'h0, 8'he0, 1'b0, 16'hffe0);
        mem(agu_pkg::OP_INDIRECT, 16'h0, 8'h0, 1'b0, 16'h3d4c);
        mem(agu_pkg::OP_INDIRECT, 16'h0, 8'h0, 1'b1, 16'h1f2e);
        mem(agu_pkg::OP_BASED, 16'h0, 8'hf0, 1'b0, 16'h201e);
        mem(agu_pkg::OP_INDEXED, 16'h0, 8'h0, 1'b1, 16'h1f89);
        mem(agu_pkg::OP_INDEXED, 16'h0, 8'h0, 1'b0, 16'h1f98);
        bank_file = 64'hfff0_3d4c_5b6a_7988;
        mem(agu_pkg::OP_BASED, 16'h0, 8'h20, 1'b0, 16'h0010);
        mem(agu_pkg::OP_INDEXED, 16'h0, 8'h0, 1'b1, 16'h004b);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence: reset, then each scenario in turn
    initial
    begin
        rstn = 1'b0;
        req = '0;
        bank_select_low = 1'b0;
        bank_select_high = 1'b0;
        vec_data = 16'h0;
        bank_file = 64'h1f2e_3d4c_5b6a_7988;
        repeat (8) @(negedge clk);
        chk(16'(rsp != '0), 16'h0);
        rstn = 1'b1;
        // first request may only be taken from the third edge after release
        repeat (3) @(negedge clk);
        t_branch();
        t_regs();
        t_mem();
        stop_test();
    end
endmodule // agu_core_tb
